/* bench/bwa_lane_model.sv */
/*
 * Behavioural lane in raw serializer mode, looped back from transmit to receive.
 * Assumes the block drives tx_word, the slip request and both lane resets.
 */
`timescale 1ns/1ps
`default_nettype none

module bwa_lane_model #(
	parameter int OFF0 = 25
) (
	input wire logic lane_up,
	input wire logic [bwa_pkg::WORD_W-1:0] flip_mask,
	input wire logic [bwa_pkg::WORD_W-1:0] tx_word,
	input wire logic lane_slip_request,
	input wire logic coding_layer_reset_n,
	input wire logic serializer_layer_reset_n,
	output logic recovered_rx_clock,
	output logic lane_tx_clock,
	output logic [bwa_pkg::WORD_W-1:0] rx_word,
	output logic rx_word_valid,
	output logic rx_lane_ready,
	output logic tx_lane_ready
);
	import bwa_pkg::*;
	// --------------------------------------------------------------
	// Clocks and flags.
	// --------------------------------------------------------------
	logic [WORD_W-1:0] cur_q;
	logic [WORD_W-1:0] prev_q;
	logic [2*WORD_W-1:0] pair;
	logic [5:0] off_q;
	logic up;
	// The lane clocks run free; the receive clock lags so no edge meets the system clock.
	initial begin
		lane_tx_clock = 1'b0;
		forever #24 lane_tx_clock = ~lane_tx_clock;
	end
	initial begin
		recovered_rx_clock = 1'b0;
		#11;
		forever #24 recovered_rx_clock = ~recovered_rx_clock;
	end
	assign up = lane_up & coding_layer_reset_n & serializer_layer_reset_n;
	assign tx_lane_ready = up;
	assign rx_lane_ready = up;
	assign rx_word_valid = up;
	// --------------------------------------------------------------
	// Loopback with a movable word boundary.
	// --------------------------------------------------------------
	initial begin
		off_q = 6'(OFF0);
		cur_q = '0;
		prev_q = '0;
		rx_word = '0;
	end
	assign pair = {cur_q, prev_q} >> off_q;
	always @(posedge lane_tx_clock) begin
		prev_q <= cur_q;
		cur_q <= tx_word;
	end
	always @(posedge lane_slip_request) begin
		off_q <= (off_q == 6'(WORD_W - 1)) ? 6'h00 : off_q + 6'h01;
	end
	// A lane that is not up shows a changing pattern, never the last word.
	always @(posedge recovered_rx_clock) begin
		rx_word <= (up ? pair[WORD_W-1:0] : ~rx_word) ^ flip_mask;
	end
endmodule : bwa_lane_model

`default_nettype wire

/* bench/tb_bwa_top.sv */
/*
 * Self-checking bench: alignment, counter traffic, error events and registers.
 * Assumes the lane model starts 25 bit positions off the word boundary, 15 slips short of it.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_bwa_top;
	import bwa_pkg::*;
	// --------------------------------------------------------------
	// Signals and instances.
	// --------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic srst, psel, penable, pwrite, pready, pslverr, irq, lane_up, device_init_done;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic rxc, txc, rx_valid, rx_rdy, tx_rdy, slip, pcs_n, pma_n;
	logic [WORD_W-1:0] rx_word, tx_word, flip_mask;
	logic [WORD_W:0] expq[$];
	int mismatches = 0;
	int checks = 0;
	int nslips = 0;
	logic slip_q = 1'b0;

	always #2 clk_sys = ~clk_sys;

	bwa_top u_bwa_top (.clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .recovered_rx_clock(rxc),
		.lane_tx_clock(txc), .rx_word(rx_word), .rx_word_valid(rx_valid),
		.rx_lane_ready(rx_rdy), .tx_lane_ready(tx_rdy), .device_init_done(device_init_done),
		.tx_word(tx_word), .lane_slip_request(slip), .coding_layer_reset_n(pcs_n),
		.serializer_layer_reset_n(pma_n));

	bwa_lane_model #(.OFF0(25)) u_bwa_lane_model (.lane_up(lane_up), .flip_mask(flip_mask),
		.tx_word(tx_word), .lane_slip_request(slip), .coding_layer_reset_n(pcs_n),
		.serializer_layer_reset_n(pma_n), .recovered_rx_clock(rxc), .lane_tx_clock(txc),
		.rx_word(rx_word), .rx_word_valid(rx_valid), .rx_lane_ready(rx_rdy),
		.tx_lane_ready(tx_rdy));

	// --------------------------------------------------------------
	// Tasks.
	// --------------------------------------------------------------
	task automatic check(input string what, input logic [WORD_W:0] seen,
		input logic [WORD_W:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic timeout(input string what);
		mismatches++;
		$display("Error %s expected event seen none", what);
		end_of_test();
	endtask : timeout

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (i == 50) timeout("pready");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Each read notes its expected error flag and data before the transfer starts.
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic err);
		expq.push_back({8'h00, err, d});
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic wait_irq(input int bound);
		int i;
		for (i = 0; i < bound; i++) begin
			@(posedge clk_sys);
			if (irq === 1'b1) break;
		end
		if (i == bound) timeout("irq");
	endtask : wait_irq

	// Flip one random bit of exactly one received word.
	task automatic inject();
		logic [WORD_W-1:0] m;
		m = 40'h1 << ($urandom % WORD_W);
		@(posedge rxc);
		@(posedge clk_sys);
		flip_mask <= m;
		@(posedge rxc);
		@(posedge clk_sys);
		flip_mask <= '0;
	endtask : inject

	// --------------------------------------------------------------
	// Result monitor.
	// --------------------------------------------------------------
	always @(posedge clk_sys) begin
		slip_q <= slip;
		if (slip === 1'b1 && slip_q === 1'b0) nslips++;
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (expq.size() == 0) begin
				timeout("read note");
			end else begin
				check("apb read", {8'h00, pslverr, prdata}, expq.pop_front());
			end
		end
	end

	// --------------------------------------------------------------
	// Main sequence.
	// --------------------------------------------------------------
	initial begin
		logic [WORD_W-1:0] w;
		void'($urandom(56567));
		srst = 1'b1;
		{psel, penable, pwrite, lane_up, device_init_done} = '0;
		paddr = '0;
		pwdata = '0;
		flip_mask = '0;
		repeat (12) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		check("tx word", 41'(tx_word), 41'(COMMA_WORD));
		check("lane resets", 41'({pcs_n, pma_n, slip}), 41'h0);
		rd(REG_IRQ_MASK, 32'(IRQ_MASK_RST), 1'b0);
		apb(1'b1, 12'h030, $urandom);
		rd(12'h030, 32'h0, 1'b1);
		lane_up <= 1'b1;
		device_init_done <= 1'b1;
		repeat (300) @(negedge clk_sys);
		check("lane resets", 41'({pcs_n, pma_n}), 41'h3);
		check("tx before start", 41'(tx_word), 41'(COMMA_WORD));
		check("slips before start", 41'(nslips), 41'h0);
		rd(REG_STATUS, 32'h0000000e, 1'b0);
		apb(1'b1, REG_IRQ_MASK, 32'h3);
		apb(1'b1, REG_CTRL, 32'h1);
		wait_irq(20000);
		check("slip count", 41'(nslips), 41'd15);
		rd(REG_IRQ_STAT, 32'h2, 1'b0);
		repeat (200) @(posedge clk_sys);
		rd(REG_STATUS, 32'h0000001f, 1'b0);
		@(posedge txc);
		w = tx_word;
		@(posedge txc);
		check("tx counter", 41'(tx_word), 41'(w + 40'h1));
		apb(1'b1, REG_IRQ_STAT, 32'h3);
		repeat (2) @(negedge clk_sys);
		check("irq cleared", 41'(irq), 41'h0);
		rd(REG_ERR_COUNT, 32'h0, 1'b0);
		inject();
		wait_irq(2000);
		rd(REG_IRQ_STAT, 32'h1, 1'b0);
		rd(REG_ERR_COUNT, 32'h1, 1'b0);
		rd(REG_LOG_COUNT, 32'h1, 1'b0);
		apb(1'b1, REG_IRQ_MASK, 32'h0);
		inject();
		repeat (200) @(negedge clk_sys);
		check("masked irq", 41'(irq), 41'h0);
		// Each flipped word costs two errors: the word itself, then the word after the re-seed.
		rd(REG_ERR_COUNT, 32'h4, 1'b0);
		apb(1'b1, REG_CTRL, 32'h3);
		rd(REG_ERR_COUNT, 32'h0, 1'b0);
		rd(REG_LOG_COUNT, 32'h0, 1'b0);
		repeat (4) @(posedge clk_sys);
		end_of_test();
	end
endmodule : tb_bwa_top

`default_nettype wire

/* shared/bwa_pkg.sv */
/*
 * Constants, field positions and types for the bit-slip word aligner with
 * counter loopback check.
 * Assumes a single system clock of 250 MHz and an APB register bus of 32 bits.
 */
`default_nettype none

package bwa_pkg;

	// ----------------------------------------------------------------------
	// Word and pattern.
	// ----------------------------------------------------------------------
	localparam int WORD_W = 40;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	// Four comma symbols of alternating disparity fill one lane word.
	localparam logic [WORD_W-1:0] COMMA_WORD = 40'hc14fac14fa;

	// ----------------------------------------------------------------------
	// Register offsets.
	// ----------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 12'h008;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 12'h00c;
	localparam logic [ADDR_W-1:0] REG_ERR_COUNT = 12'h010;
	localparam logic [ADDR_W-1:0] REG_LOG_COUNT = 12'h014;
	localparam logic [ADDR_W-1:0] REG_LOG_BASE = 12'h040;

	// ----------------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------------
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam int ST_ALIGNED_BIT = 0;
	localparam int ST_TX_READY_BIT = 1;
	localparam int ST_RX_READY_BIT = 2;
	localparam int ST_INIT_BIT = 3;
	localparam int ST_CHECKING_BIT = 4;
	localparam int ST_SLIP_BIT = 5;
	localparam int IRQ_W = 2;
	localparam int IRQ_ERR_BIT = 0;
	localparam int IRQ_ALIGN_BIT = 1;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

	// ----------------------------------------------------------------------
	// Error log memory.
	// ----------------------------------------------------------------------
	localparam int LOG_AW = 4;
	localparam logic [LOG_AW:0] LOG_DEPTH = 5'h10;

	// ----------------------------------------------------------------------
	// Input synchroniser slots.
	// ----------------------------------------------------------------------
	localparam int SY_RXCLK = 0;
	localparam int SY_TXCLK = 1;
	localparam int SY_RXRDY = 2;
	localparam int SY_TXRDY = 3;
	localparam int SY_RXVAL = 4;
	localparam int SY_INIT = 5;
	localparam int SY_W = 6;

	// ----------------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int LANE_RST_NS = 1000;
	localparam int LANE_RST_CYC = (LANE_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RST_CNT_W = 9;
	localparam logic [2:0] SLIP_HIGH_WORDS = 3'h2;
	localparam logic [2:0] SLIP_WAIT_WORDS = 3'h4;

	typedef enum logic [2:0] {AL_RESET, AL_CHECK, AL_SLIP, AL_SETTLE, AL_DONE} bwa_align_t;
	typedef enum logic {VF_SEEK, VF_CHECK} bwa_verify_t;

endpackage : bwa_pkg

`default_nettype wire

/* verilog/bwa_log_mem.sv */
/*
 * Small error log memory: one write port, one read port with registered data.
 * Assumes both ports run on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module bwa_log_mem (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic we,
	input wire logic [bwa_pkg::LOG_AW-1:0] waddr,
	input wire logic [bwa_pkg::DATA_W-1:0] wdata,
	input wire logic [bwa_pkg::LOG_AW-1:0] raddr,
	output logic [bwa_pkg::DATA_W-1:0] rdata
);
	import bwa_pkg::*;

	logic [DATA_W-1:0] mem_q [0:(1<<LOG_AW)-1];
	logic [DATA_W-1:0] rdata_q;

	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= mem_q[raddr];
		end
	end

	assign rdata = rdata_q;

endmodule : bwa_log_mem

`default_nettype wire

/* verilog/bwa_top.sv */
/*
 * Bit-slip word aligner, counter source and counter verifier for one lane in
 * raw serializer mode, with an APB register slave and a level interrupt.
 * Assumes lane clocks far slower than clk_sys; lane inputs are asynchronous.
 */
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Before alignment the source sends comma words and holds its counter.
// - Each transmit word is a full 40-bit comma pattern during training.
// - A state machine compares each received word in AL_CHECK with the comma word.
// - On mismatch the aligner keeps requesting slips until the comma appears.
// - On comma match alignment-done rises and starts source and verifier.
// - After alignment the source sends a 40-bit counter, plus one per word.
// - The verifier compares each word with its expected count, flags mismatches.
// - Checking starts only after alignment, alongside counter transmission.
// - Error flags and counts are readable by host software.
// - Lane coding and serializer resets are held low at start-up.
// - Aligner and verifier follow the receive clock, source the transmit clock.
// - Status crossing into the host domain passes a proper crossing.
// - Host side logic has its own clock, here the system clock.
// - Source reset releases only with tx ready, init done and start.
// - Verifier reset releases only with rx ready, init done and start.
module bwa_top (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [bwa_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [bwa_pkg::DATA_W-1:0] pwdata,
	output logic [bwa_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic recovered_rx_clock,
	input wire logic lane_tx_clock,
	input wire logic [bwa_pkg::WORD_W-1:0] rx_word,
	input wire logic rx_word_valid,
	input wire logic rx_lane_ready,
	input wire logic tx_lane_ready,
	input wire logic device_init_done,
	output logic [bwa_pkg::WORD_W-1:0] tx_word,
	output logic lane_slip_request,
	output logic coding_layer_reset_n,
	output logic serializer_layer_reset_n
);
	import bwa_pkg::*;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		case (a)
			REG_CTRL, REG_STATUS, REG_IRQ_STAT, REG_IRQ_MASK,
			REG_ERR_COUNT, REG_LOG_COUNT: is_mapped = 1'b1;
			default: is_mapped = (a[ADDR_W-1:6] == REG_LOG_BASE[ADDR_W-1:6]) && (a[1:0] == 2'h0);
		endcase
	endfunction : is_mapped

	// ----------------------------------------------------------------------
	// Input synchronisers and lane clock edges.
	// ----------------------------------------------------------------------
	// Words are taken on the falling edge of the lane clock, half a lane
	// period after the lane launched them, so the two-stage copy is settled.
	logic [SY_W+WORD_W-1:0] sy1_q, sy2_q;
	logic [1:0] clk3_q;
	logic [WORD_W-1:0] rx_word_s;
	logic rx_fall, tx_fall, word_stb;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sy1_q <= '0;
			sy2_q <= '0;
			clk3_q <= 2'h0;
		end else begin
			sy1_q <= {device_init_done, rx_word_valid, tx_lane_ready, rx_lane_ready,
				lane_tx_clock, recovered_rx_clock, rx_word};
			sy2_q <= sy1_q;
			clk3_q <= {sy2_q[WORD_W+SY_TXCLK], sy2_q[WORD_W+SY_RXCLK]};
		end
	end

	assign rx_word_s = sy2_q[WORD_W-1:0];
	assign rx_fall = clk3_q[0] & ~sy2_q[WORD_W+SY_RXCLK];
	assign tx_fall = clk3_q[1] & ~sy2_q[WORD_W+SY_TXCLK];

	// ----------------------------------------------------------------------
	// Lane resets and block reset releases.
	// ----------------------------------------------------------------------
	logic [RST_CNT_W-1:0] rst_cnt_q, rst_cnt_d;
	logic lane_rel_q, lane_rel_d, tx_run_q, tx_run_d, rx_run_q, rx_run_d;
	logic start_q;

	always_comb begin
		rst_cnt_d = rst_cnt_q;
		lane_rel_d = lane_rel_q;
		if (rst_cnt_q != RST_CNT_W'(LANE_RST_CYC)) begin
			rst_cnt_d = rst_cnt_q + 1'b1;
		end else begin
			lane_rel_d = 1'b1;
		end
		tx_run_d = lane_rel_q & sy2_q[WORD_W+SY_TXRDY] & sy2_q[WORD_W+SY_INIT] & start_q;
		rx_run_d = lane_rel_q & sy2_q[WORD_W+SY_RXRDY] & sy2_q[WORD_W+SY_INIT] & start_q;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rst_cnt_q <= '0;
			lane_rel_q <= 1'b0;
			tx_run_q <= 1'b0;
			rx_run_q <= 1'b0;
		end else begin
			rst_cnt_q <= rst_cnt_d;
			lane_rel_q <= lane_rel_d;
			tx_run_q <= tx_run_d;
			rx_run_q <= rx_run_d;
		end
	end

	assign coding_layer_reset_n = lane_rel_q;
	assign serializer_layer_reset_n = lane_rel_q;
	assign word_stb = rx_fall & sy2_q[WORD_W+SY_RXVAL] & rx_run_q;

	// ----------------------------------------------------------------------
	// Word aligner.
	// ----------------------------------------------------------------------
	bwa_align_t al_q, al_d;
	logic [2:0] al_cnt_q, al_cnt_d;
	logic slip_q, slip_d, aligned;

	always_comb begin
		al_d = al_q;
		al_cnt_d = al_cnt_q;
		slip_d = slip_q;
		case (al_q)
			AL_RESET: begin
				al_d = AL_CHECK;
			end
			AL_CHECK: begin
				if (word_stb) begin
					if (rx_word_s == COMMA_WORD) begin
						al_d = AL_DONE;
					end else begin
						al_d = AL_SLIP;
						slip_d = 1'b1;
						al_cnt_d = 3'h0;
					end
				end
			end
			AL_SLIP: begin
				if (word_stb) begin
					al_cnt_d = al_cnt_q + 3'h1;
					if (al_cnt_q == SLIP_HIGH_WORDS - 3'h1) begin
						al_d = AL_SETTLE;
						slip_d = 1'b0;
						al_cnt_d = 3'h0;
					end
				end
			end
			AL_SETTLE: begin
				if (word_stb) begin
					al_cnt_d = al_cnt_q + 3'h1;
					if (al_cnt_q == SLIP_WAIT_WORDS - 3'h1) begin
						al_d = AL_CHECK;
					end
				end
			end
			AL_DONE: begin
				al_d = AL_DONE;
			end
			default: begin
				al_d = AL_RESET;
			end
		endcase
		if (!rx_run_q) begin
			al_d = AL_RESET;
			slip_d = 1'b0;
			al_cnt_d = 3'h0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			al_q <= AL_RESET;
			al_cnt_q <= 3'h0;
			slip_q <= 1'b0;
		end else begin
			al_q <= al_d;
			al_cnt_q <= al_cnt_d;
			slip_q <= slip_d;
		end
	end

	assign aligned = (al_q == AL_DONE);
	assign lane_slip_request = slip_q;

	// ----------------------------------------------------------------------
	// Counter source.
	// ----------------------------------------------------------------------
	logic [WORD_W-1:0] tx_q, tx_d, ctr_q, ctr_d;

	always_comb begin
		tx_d = tx_q;
		ctr_d = ctr_q;
		if (!tx_run_q || !aligned) begin
			ctr_d = '0;
			if (tx_fall) begin
				tx_d = COMMA_WORD;
			end
		end else if (tx_fall) begin
			tx_d = ctr_q;
			ctr_d = ctr_q + 40'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tx_q <= COMMA_WORD;
			ctr_q <= '0;
		end else begin
			tx_q <= tx_d;
			ctr_q <= ctr_d;
		end
	end

	assign tx_word = tx_q;

	// ----------------------------------------------------------------------
	// Counter verifier and error log.
	// ----------------------------------------------------------------------
	// Commas still in flight after alignment are skipped; the first counter
	// word seeds the expected value, and a mismatch re-seeds it so one lost
	// word costs one error, not an endless run of them.
	bwa_verify_t vf_q, vf_d;
	logic [WORD_W-1:0] exp_q, exp_d;
	logic mism_q, mism_d;
	logic [DATA_W-1:0] err_cnt_q, err_cnt_d;
	logic [LOG_AW:0] log_cnt_q, log_cnt_d;
	logic clr_err;

	always_comb begin
		vf_d = vf_q;
		exp_d = exp_q;
		mism_d = 1'b0;
		if (!rx_run_q || !aligned) begin
			vf_d = VF_SEEK;
		end else if (word_stb) begin
			exp_d = rx_word_s + 40'h1;
			if (vf_q == VF_SEEK) begin
				if (rx_word_s != COMMA_WORD) begin
					vf_d = VF_CHECK;
				end
			end else begin
				mism_d = (rx_word_s != exp_q);
			end
		end
		err_cnt_d = err_cnt_q;
		log_cnt_d = log_cnt_q;
		if (clr_err) begin
			// An error in the clearing cycle survives the clear, so none is lost.
			err_cnt_d = {31'h0, mism_q};
			log_cnt_d = {4'h0, mism_q};
		end else if (mism_q) begin
			if (err_cnt_q != 32'hffffffff) begin
				err_cnt_d = err_cnt_q + 32'h1;
			end
			if (log_cnt_q != LOG_DEPTH) begin
				log_cnt_d = log_cnt_q + 5'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			vf_q <= VF_SEEK;
			exp_q <= '0;
			mism_q <= 1'b0;
			err_cnt_q <= 32'h0;
			log_cnt_q <= '0;
		end else begin
			vf_q <= vf_d;
			exp_q <= exp_d;
			mism_q <= mism_d;
			err_cnt_q <= err_cnt_d;
			log_cnt_q <= log_cnt_d;
		end
	end

	logic [WORD_W-1:0] bad_word_q;
	logic [DATA_W-1:0] log_rdata;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bad_word_q <= '0;
		end else if (word_stb) begin
			bad_word_q <= rx_word_s;
		end
	end

	bwa_log_mem u_log (
		.clk_sys(clk_sys),
		.srst(srst),
		.we(mism_q && (clr_err || log_cnt_q != LOG_DEPTH)),
		.waddr(clr_err ? 4'h0 : log_cnt_q[LOG_AW-1:0]),
		.wdata(bad_word_q[DATA_W-1:0]),
		.raddr(paddr[LOG_AW+1:2]),
		.rdata(log_rdata)
	);

	// ----------------------------------------------------------------------
	// APB slave and interrupt.
	// ----------------------------------------------------------------------
	// Host software sits on clk_sys, so every lane flag it sees has already
	// passed the two-stage synchroniser above.
	logic wr_acc, rd_setup;
	logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, irq_ev;
	logic start_d, al_prev_q, log_sel_q, log_sel_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;

	assign wr_acc = psel & penable & pwrite & is_mapped(paddr);
	assign rd_setup = psel & ~penable & ~pwrite;
	assign clr_err = wr_acc & (paddr == REG_CTRL) & pwdata[CTRL_CLR_BIT];
	assign irq_ev = {aligned & ~al_prev_q, mism_q};

	always_comb begin
		start_d = start_q;
		irq_mask_d = irq_mask_q;
		irq_stat_d = irq_stat_q;
		if (wr_acc && paddr == REG_CTRL) begin
			start_d = pwdata[CTRL_START_BIT];
		end
		if (wr_acc && paddr == REG_IRQ_MASK) begin
			irq_mask_d = pwdata[IRQ_W-1:0];
		end
		if (wr_acc && paddr == REG_IRQ_STAT) begin
			irq_stat_d = irq_stat_q & ~pwdata[IRQ_W-1:0];
		end
		irq_stat_d = irq_stat_d | irq_ev;
		rdata_d = rdata_q;
		log_sel_d = log_sel_q;
		if (rd_setup) begin
			log_sel_d = 1'b0;
			case (paddr)
				REG_CTRL: rdata_d = {31'h0, start_q};
				REG_STATUS: rdata_d = {26'h0, slip_q, vf_q == VF_CHECK,
					sy2_q[WORD_W+SY_INIT], sy2_q[WORD_W+SY_RXRDY],
					sy2_q[WORD_W+SY_TXRDY], aligned};
				REG_IRQ_STAT: rdata_d = {30'h0, irq_stat_q};
				REG_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
				REG_ERR_COUNT: rdata_d = err_cnt_q;
				REG_LOG_COUNT: rdata_d = {27'h0, log_cnt_q};
				default: begin
					rdata_d = 32'h0;
					log_sel_d = is_mapped(paddr);
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			start_q <= 1'b0;
			irq_mask_q <= IRQ_MASK_RST;
			irq_stat_q <= '0;
			al_prev_q <= 1'b0;
			rdata_q <= 32'h0;
			log_sel_q <= 1'b0;
		end else begin
			start_q <= start_d;
			irq_mask_q <= irq_mask_d;
			irq_stat_q <= irq_stat_d;
			al_prev_q <= aligned;
			rdata_q <= rdata_d;
			log_sel_q <= log_sel_d;
		end
	end

	assign prdata = log_sel_q ? log_rdata : rdata_q;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~is_mapped(paddr);
	assign irq = |(irq_stat_q & irq_mask_q);

	// ----------------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	sequence slip_low_s;
		!lane_slip_request [*8];
	endsequence

	comma_hold_a: assert property (!aligned |=> ctr_q == '0) else $error("counter moved");
	comma_word_a: assert property (tx_fall && !aligned |=> tx_word == COMMA_WORD)
		else $error("comma word not sent");
	slip_on_miss_a: assert property (al_q == AL_CHECK && word_stb && rx_word_s != COMMA_WORD
		|=> lane_slip_request && !aligned) else $error("no slip on miss");
	slip_gap_a: assert property ($fell(lane_slip_request) |-> slip_low_s)
		else $error("slip gap too short");
	align_done_a: assert property (al_q == AL_CHECK && word_stb && rx_word_s == COMMA_WORD
		|=> aligned && !lane_slip_request) else $error("alignment not flagged");
	counter_step_a: assert property (tx_fall && aligned && tx_run_q
		|=> tx_word == $past(ctr_q) && ctr_q == $past(ctr_q) + 40'h1) else $error("counter step");
	mismatch_flag_a: assert property (aligned && rx_run_q && vf_q == VF_CHECK && word_stb
		&& rx_word_s != exp_q |=> mism_q ##1 irq_stat_q[IRQ_ERR_BIT]) else $error("error missed");
	no_early_check_a: assert property (!aligned |=> !mism_q) else $error("check before align");
	tx_release_a: assert property (!(tx_lane_ready && device_init_done && start_q)
		|-> ##[1:3] !tx_run_q) else $error("source released early");
	rx_release_a: assert property (!(rx_lane_ready && device_init_done && start_q)
		|-> ##[1:3] !rx_run_q) else $error("verifier released early");
	lane_reset_a: assert property (rst_cnt_q < RST_CNT_W'(LANE_RST_CYC)
		|-> !coding_layer_reset_n && !serializer_layer_reset_n) else $error("lane reset short");

endmodule : bwa_top

`default_nettype wire
